//--- core/ict_seq.sv
// Instruction sequencer that times each instruction in oscillator clocks
`timescale 1ns/100ps
`default_nettype none
`include "ict_map.svh"
module ict_seq #(
  parameter int W            = 8,
  parameter int RESTART_CYC  = 65536
) (
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rstn_i,
  // Instruction issue
  input  wire logic                issue_i,
  input  wire ict_pkg::ict_op_t    op_i,
  input  wire ict_pkg::ict_pmove_t pmove_i,
  input  wire ict_pkg::ict_cmode_t cmode_i,
  input  wire ict_pkg::ict_amode_t amode_i,
  input  wire logic                mem_opnd_i,
  input  wire logic                cond_true_i,
  input  wire logic                two_word_i,
  // Memory placement and waits
  input  wire logic                x_ext_i,
  input  wire logic                x2_ext_i,
  input  wire logic                p_ext_i,
  input  wire logic                pdata_ext_i,
  input  wire logic                fetch_ext_i,
  input  wire logic [W-1:0]        xmem_wait_states_i,
  input  wire logic [W-1:0]        pmem_wait_states_i,
  // Wake events
  input  wire logic                int_pending_i,
  input  wire logic                osc_restart_i,
  // Status
  output logic                     busy_o,
  output logic                     done_o,
  output logic                     icyc_o,
  output logic                     osc_en_o,
  output logic                     core_clk_en_o,
  output logic [W-1:0]             cost_o
);
  ict_pkg::ict_state_t state_r;
  logic [W-1:0]  cost_nxt;
  logic [W-1:0]  cnt_r;
  logic [16:0]   wake_r;
  logic          phase_r;
  logic          op_r_idle;

  ict_cost #(.W(W)) u_cost (
    .op_i               (op_i),
    .pmove_i            (pmove_i),
    .cmode_i            (cmode_i),
    .amode_i            (amode_i),
    .mem_opnd_i         (mem_opnd_i),
    .cond_true_i        (cond_true_i),
    .two_word_i         (two_word_i),
    .x_ext_i            (x_ext_i),
    .x2_ext_i           (x2_ext_i),
    .p_ext_i            (p_ext_i),
    .pdata_ext_i        (pdata_ext_i),
    .fetch_ext_i        (fetch_ext_i),
    .xmem_wait_states_i (xmem_wait_states_i),
    .pmem_wait_states_i (pmem_wait_states_i),
    .cost_o             (cost_nxt)
  );

  // Sequencer states
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_r <= ict_pkg::ICT_ST_IDLE;
    else
      unique case (state_r)
        ict_pkg::ICT_ST_IDLE:
          if (issue_i)
            state_r <= (op_i == ict_pkg::ICT_OP_HALT) ? ict_pkg::ICT_ST_HALT
                                                      : ict_pkg::ICT_ST_RUN;
        ict_pkg::ICT_ST_RUN:
          if (cnt_r == W'(1) && !(op_r_idle && !int_pending_i))
            state_r <= ict_pkg::ICT_ST_IDLE;
        ict_pkg::ICT_ST_HALT:
          if (osc_restart_i)
            state_r <= ict_pkg::ICT_ST_WAKE;
        ict_pkg::ICT_ST_WAKE:
          if (wake_r == 17'(RESTART_CYC - 1))
            state_r <= ict_pkg::ICT_ST_IDLE;
        default:
          state_r <= ict_pkg::ICT_ST_IDLE;
      endcase
  end

  // Idle instruction holds past its minimum until an interrupt arrives
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      op_r_idle <= 1'b0;
    else if (state_r == ict_pkg::ICT_ST_IDLE && issue_i)
      op_r_idle <= (op_i == ict_pkg::ICT_OP_IDLE);
  end

  // Oscillator clock countdown of the running instruction
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_r <= '0;
    else if (state_r == ict_pkg::ICT_ST_IDLE && issue_i)
      cnt_r <= cost_nxt;
    else if (state_r == ict_pkg::ICT_ST_RUN && cnt_r > W'(1))
      cnt_r <= W'(cnt_r - W'(1));
  end

  // Restart counter runs only after the oscillator is back
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wake_r <= '0;
    else if (state_r == ict_pkg::ICT_ST_WAKE)
      wake_r <= 17'(wake_r + 17'h00001);
    else
      wake_r <= '0;
  end

  // Instruction cycle phase, two oscillator clocks each
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      phase_r <= 1'b0;
    else if (state_r == ict_pkg::ICT_ST_RUN)
      phase_r <= ~phase_r;
    else
      phase_r <= 1'b0;
  end

  // Registered outputs
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_o        <= 1'b0;
      done_o        <= 1'b0;
      icyc_o        <= 1'b0;
      osc_en_o      <= 1'b1;
      core_clk_en_o <= 1'b1;
      cost_o        <= '0;
    end
    else
    begin
      busy_o   <= (state_r != ict_pkg::ICT_ST_IDLE) || issue_i;
      done_o   <= state_r == ict_pkg::ICT_ST_RUN && cnt_r == W'(1)
                  && !(op_r_idle && !int_pending_i);
      icyc_o   <= state_r == ict_pkg::ICT_ST_RUN && phase_r;
      osc_en_o <= !(state_r == ict_pkg::ICT_ST_HALT && !osc_restart_i)
                  && !(state_r == ict_pkg::ICT_ST_IDLE && issue_i
                       && op_i == ict_pkg::ICT_OP_HALT);
      core_clk_en_o <= (state_r == ict_pkg::ICT_ST_IDLE && !(issue_i
                        && op_i == ict_pkg::ICT_OP_HALT))
                       || state_r == ict_pkg::ICT_ST_RUN
                       || (state_r == ict_pkg::ICT_ST_WAKE
                           && wake_r == 17'(RESTART_CYC - 1));
      if (state_r == ict_pkg::ICT_ST_IDLE && issue_i)
        cost_o <= cost_nxt;
    end
  end
endmodule
`default_nettype wire

//--- core/ict_map.svh
// Constants for the instruction cycle timing block
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH
`define ICT_RESTART_COUNT  17'h10000
`define ICT_IDLE_MIN       8'h10
`define ICT_BASE_SIMPLE    8'h02
`define ICT_BASE_BRANCH    8'h04
`define ICT_BASE_JUMP      8'h06
`define ICT_BASE_CALL      8'h08
`define ICT_BASE_PMOVE     8'h08
`define ICT_BASE_BFBR      8'h08
`define ICT_BASE_RET       8'h0A
`define ICT_TRUE_EXTRA     8'h02
`define ICT_IMM_EXTRA      8'h02
`define ICT_AM_SHORT_CYC   8'h02
`define ICT_AM_LONG_CYC    8'h04
`define ICT_AM_ABS_CYC     8'h02
`define ICT_OSC_PER_ICYC   8'h02
`endif

//--- core/ict_pkg.sv
// Types for the instruction cycle timing block
package ict_pkg;
  typedef enum logic [3:0] {
    ICT_OP_SIMPLE   = 4'h0,
    ICT_OP_CTRL     = 4'h1,
    ICT_OP_PMOVE    = 4'h2,
    ICT_OP_BFMOD    = 4'h3,
    ICT_OP_BFTEST   = 4'h4,
    ICT_OP_BFBR     = 4'h5,
    ICT_OP_CBRANCH  = 4'h6,
    ICT_OP_CJUMP    = 4'h7,
    ICT_OP_UJUMP    = 4'h8,
    ICT_OP_CALL     = 4'h9,
    ICT_OP_RET      = 4'hA,
    ICT_OP_IDLE     = 4'hB,
    ICT_OP_HALT     = 4'hC,
    ICT_OP_DUALREAD = 4'hD
  } ict_op_t;
  typedef enum logic [1:0] {
    ICT_PM_NONE = 2'h0,
    ICT_PM_X    = 2'h1,
    ICT_PM_XX   = 2'h2
  } ict_pmove_t;
  typedef enum logic [1:0] {
    ICT_CM_IMM = 2'h0,
    ICT_CM_REG = 2'h1,
    ICT_CM_MEM = 2'h2
  } ict_cmode_t;
  typedef enum logic [2:0] {
    ICT_AM_NONE  = 3'h0,
    ICT_AM_IDXN  = 3'h1,
    ICT_AM_IMM   = 3'h2,
    ICT_AM_ABS   = 3'h3,
    ICT_AM_SDISP = 3'h4,
    ICT_AM_LDISP = 3'h5
  } ict_amode_t;
  typedef enum logic [3:0] {
    ICT_ST_IDLE = 4'b0001,
    ICT_ST_RUN  = 4'b0010,
    ICT_ST_HALT = 4'b0100,
    ICT_ST_WAKE = 4'b1000
  } ict_state_t;
endpackage

//--- core/ict_cost.sv
// Combinational cost calculator for one instruction
`timescale 1ns/100ps
`default_nettype none
`include "ict_map.svh"
module ict_cost #(
  parameter int W = 8
) (
  // Instruction description
  input  wire ict_pkg::ict_op_t    op_i,
  input  wire ict_pkg::ict_pmove_t pmove_i,
  input  wire ict_pkg::ict_cmode_t cmode_i,
  input  wire ict_pkg::ict_amode_t amode_i,
  input  wire logic                mem_opnd_i,
  input  wire logic                cond_true_i,
  input  wire logic                two_word_i,
  // Memory placement and waits
  input  wire logic                x_ext_i,
  input  wire logic                x2_ext_i,
  input  wire logic                p_ext_i,
  input  wire logic                pdata_ext_i,
  input  wire logic                fetch_ext_i,
  input  wire logic [W-1:0]        xmem_wait_states_i,
  input  wire logic [W-1:0]        pmem_wait_states_i,
  // Result in oscillator clocks
  output logic [W-1:0]             cost_o
);
  logic [W-1:0] xacc;
  logic [W-1:0] xxacc;
  logic [W-1:0] pacc;
  logic [W-1:0] pdacc;
  logic [W-1:0] amc;
  logic [W-1:0] pmx;
  logic [W-1:0] jmpx;
  logic [W-1:0] tru;
  always_comb
  begin
    xacc  = x_ext_i ? xmem_wait_states_i : '0;
    xxacc = (x_ext_i || x2_ext_i) ? xmem_wait_states_i : '0;
    pacc  = p_ext_i ? pmem_wait_states_i : '0;
    pdacc = pdata_ext_i ? pmem_wait_states_i : '0;
    tru = cond_true_i ? W'(`ICT_TRUE_EXTRA) : '0;
    unique case (amode_i)
      ict_pkg::ICT_AM_IDXN:  amc = W'(`ICT_AM_SHORT_CYC);
      ict_pkg::ICT_AM_IMM:   amc = W'(`ICT_AM_ABS_CYC);
      ict_pkg::ICT_AM_ABS:   amc = W'(`ICT_AM_ABS_CYC);
      ict_pkg::ICT_AM_SDISP: amc = W'(`ICT_AM_SHORT_CYC);
      ict_pkg::ICT_AM_LDISP: amc = W'(`ICT_AM_LONG_CYC);
      default:               amc = '0;
    endcase
    unique case (pmove_i)
      ict_pkg::ICT_PM_X:  pmx = xacc;
      ict_pkg::ICT_PM_XX: pmx = xxacc;
      default:            pmx = '0;
    endcase
    jmpx = W'(pacc + pacc);
    if (two_word_i && fetch_ext_i)
    begin
      jmpx = W'(jmpx + pmem_wait_states_i);
    end
    unique case (op_i)
      ict_pkg::ICT_OP_CTRL:
        unique case (cmode_i)
          ict_pkg::ICT_CM_IMM: cost_o = W'(`ICT_BASE_SIMPLE + `ICT_IMM_EXTRA);
          ict_pkg::ICT_CM_MEM: cost_o = W'(`ICT_BASE_SIMPLE + amc + xacc);
          default:             cost_o = W'(`ICT_BASE_SIMPLE);
        endcase
      ict_pkg::ICT_OP_PMOVE:   cost_o = W'(`ICT_BASE_PMOVE + pdacc);
      ict_pkg::ICT_OP_BFMOD:
        cost_o = mem_opnd_i ? W'(`ICT_BASE_BRANCH + amc + xacc + xacc)
                            : W'(`ICT_BASE_BRANCH);
      ict_pkg::ICT_OP_BFTEST:
        cost_o = mem_opnd_i ? W'(`ICT_BASE_BRANCH + amc + xacc)
                            : W'(`ICT_BASE_BRANCH);
      ict_pkg::ICT_OP_BFBR:
        cost_o = W'(`ICT_BASE_BFBR + tru + amc + xacc + xacc + tru + jmpx);
      ict_pkg::ICT_OP_CBRANCH: cost_o = W'(`ICT_BASE_BRANCH + tru + jmpx);
      ict_pkg::ICT_OP_CJUMP:   cost_o = W'(`ICT_BASE_BRANCH + tru + jmpx);
      ict_pkg::ICT_OP_UJUMP:   cost_o = W'(`ICT_BASE_JUMP + jmpx);
      ict_pkg::ICT_OP_CALL:    cost_o = W'(`ICT_BASE_CALL + jmpx);
      ict_pkg::ICT_OP_RET:
        cost_o = W'(`ICT_BASE_RET + pacc + pacc + xacc + xacc);
      ict_pkg::ICT_OP_IDLE:    cost_o = W'(`ICT_IDLE_MIN);
      ict_pkg::ICT_OP_DUALREAD:
        cost_o = (pmove_i == ict_pkg::ICT_PM_XX)
               ? W'(`ICT_BASE_SIMPLE + pmx) : W'(`ICT_BASE_SIMPLE);
      default:                 cost_o = W'(`ICT_BASE_SIMPLE + pmx);
    endcase
  end
endmodule
`default_nettype wire

//--- bench/ict_seq_assertions.sv
// Assertion checker bound to the instruction sequencer
`timescale 1ns/100ps
`default_nettype none
module ict_seq_chk #(
  parameter int W           = 8,
  parameter int RESTART_CYC = 65536
) (
  // Sequencer ports
  input wire logic             mclk_i,
  input wire logic             rstn_i,
  input wire logic             issue_i,
  input wire ict_pkg::ict_op_t op_i,
  input wire logic             osc_restart_i,
  input wire logic             busy_o,
  input wire logic             done_o,
  input wire logic             icyc_o,
  input wire logic             osc_en_o,
  input wire logic             core_clk_en_o,
  input wire logic [W-1:0]     cost_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  ict_pkg::ict_op_t op_r;
  logic [31:0]      cnt_r;
  // Wide count: cannot wrap within one instruction
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      op_r  <= ict_pkg::ICT_OP_SIMPLE;
      cnt_r <= 32'h0;
    end
    else if (issue_i && (!busy_o || done_o))
    begin
      // Sequencer is idle again in the done cycle
      op_r  <= op_i;
      cnt_r <= 32'h0;
    end
    else
      cnt_r <= cnt_r + 32'h1;
  end
  a_take_busy: assert property (issue_i && (!busy_o || done_o)
    |=> busy_o) else $error("issue not taken");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done too long");
  a_done_count: assert property (done_o && op_r != ict_pkg::ICT_OP_IDLE
    && op_r != ict_pkg::ICT_OP_HALT |-> cnt_r == 32'(cost_o))
    else $error("duration differs from cost");
  a_idle_min: assert property (done_o && op_r == ict_pkg::ICT_OP_IDLE
    |-> cnt_r >= 32'h10) else $error("idle too short");
  a_cost_hold: assert property (busy_o && $past(busy_o)
    && !$past(done_o) |-> $stable(cost_o))
    else $error("cost moved while busy");
  a_halt_stop: assert property (issue_i && (!busy_o || done_o)
    && op_i == ict_pkg::ICT_OP_HALT |=> !osc_en_o && !core_clk_en_o)
    else $error("halt left clocks running");
  a_halt_hold: assert property (!osc_en_o && !osc_restart_i |=> !osc_en_o)
    else $error("oscillator restarted alone");
  a_icyc_alt: assert property (icyc_o |=> !icyc_o)
    else $error("instruction cycle pulse too close");
endmodule
bind ict_seq ict_seq_chk #(.W(W), .RESTART_CYC(RESTART_CYC)) i_ict_seq_chk (
  .mclk_i, .rstn_i, .issue_i, .op_i, .osc_restart_i, .busy_o, .done_o,
  .icyc_o, .osc_en_o, .core_clk_en_o, .cost_o);
`default_nettype wire

//--- bench/ict_mem_model.sv
// Memory placement model: upper half of each space is external
`timescale 1ns/100ps
`default_nettype none
module ict_mem_model (
  // Access addresses
  input  wire logic [15:0] xa_i,
  input  wire logic [15:0] xb_i,
  input  wire logic [15:0] pa_i,
  input  wire logic [15:0] pd_i,
  input  wire logic [15:0] fa_i,
  // Placement; internal memory never stalls
  output logic             xa_o,
  output logic             xb_o,
  output logic             pa_o,
  output logic             pd_o,
  output logic             fa_o
);
  assign xa_o = xa_i[15];
  assign xb_o = xb_i[15];
  assign pa_o = pa_i[15];
  assign pd_o = pd_i[15];
  assign fa_o = fa_i[15];
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Random and corner-case bench for the instruction sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int RC = 16;
  logic mclk_i = 1'h0, rstn_i = 1'h0, issue_i = 1'h0, mem_opnd_i = 1'h0;
  logic cond_true_i = 1'h0, two_word_i = 1'h0, int_pending_i = 1'h0;
  logic osc_restart_i = 1'h0;
  ict_pkg::ict_op_t    op_i = ict_pkg::ICT_OP_SIMPLE;
  ict_pkg::ict_pmove_t pmove_i = ict_pkg::ICT_PM_NONE;
  ict_pkg::ict_cmode_t cmode_i = ict_pkg::ICT_CM_IMM;
  ict_pkg::ict_amode_t amode_i = ict_pkg::ICT_AM_NONE;
  logic [15:0] xa_i = 16'h0, xb_i = 16'h0, pa_i = 16'h0;
  logic [15:0] pd_i = 16'h0, fa_i = 16'h0;
  logic [7:0]  xws = 8'h0, pws = 8'h0, cost_o;
  logic xe, xbe, pe, pde, fe, busy_o, done_o, icyc_o, osc_en_o, cen;
  int   miscompares = 0, num_checks = 0, seed = 17;
  int   n, ic, r, pm, cm, am, xd, pj, av, c2, fx;
  ict_mem_model i_ict_mem_model (.xa_i, .xb_i, .pa_i, .pd_i, .fa_i,
    .xa_o(xe), .xb_o(xbe), .pa_o(pe), .pd_o(pde), .fa_o(fe));
  ict_seq #(.RESTART_CYC(RC)) i_ict_seq (.mclk_i, .rstn_i, .issue_i, .op_i,
    .pmove_i, .cmode_i, .amode_i, .mem_opnd_i, .cond_true_i, .two_word_i,
    .x_ext_i(xe), .x2_ext_i(xbe), .p_ext_i(pe), .pdata_ext_i(pde),
    .fetch_ext_i(fe), .xmem_wait_states_i(xws), .pmem_wait_states_i(pws),
    .int_pending_i, .osc_restart_i, .busy_o, .done_o, .icyc_o, .osc_en_o,
    .core_clk_en_o(cen), .cost_o);
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  function automatic int rnd(input int m);
    return $unsigned($random(seed)) % m;
  endfunction
  function automatic int exp_cost();
    xd = xa_i[15] ? int'(xws) : 0;
    pj = pa_i[15] ? 2 * pws : 0;
    fx = fa_i[15] ? int'(pws) : 0;
    av = am == 5 ? 4 : am == 0 ? 0 : 2;
    c2 = cond_true_i ? 2 : 0;
    case (r)
      0, 13: return 2 + (pm == 1 ? xd : pm == 2 && (xa_i[15] || xb_i[15])
        ? int'(xws) : 0);
      1: return 2 + (cm == 0 ? 2 : cm == 1 ? 0 : av + xd);
      2: return 8 + (pd_i[15] ? int'(pws) : 0);
      3: return mem_opnd_i ? 4 + av + 2 * xd : 4;
      4: return mem_opnd_i ? 4 + av + xd : 4;
      5: return 8 + 2 * c2 + av + 2 * xd + pj;
      6: return 4 + c2 + pj;
      7: return 4 + c2 + pj + fx;
      8: return 6 + pj + fx;
      9: return 8 + pj + fx;
      default: return 10 + pj + 2 * xd;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait on done or on the core clock enable
  task automatic wt(input logic wake);
    n = 0;
    ic = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
      ic += int'(icyc_o);
    end
    while ((wake ? cen : done_o) !== 1'h1 && n < 600);
    if (n >= 600)
    begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic op_wait();
    issue_i <= 1'h1;
    @(posedge mclk_i);
    issue_i <= 1'h0;
    wt(1'h0);
    @(posedge mclk_i);
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_i);
    chk(cost_o, 8'h0);
    chk(8'({busy_o, done_o, osc_en_o, cen}), 8'h3);
    rstn_i <= 1'h1;
    for (int i = 0; i < 80; i++)
    begin
      r = rnd(12);
      r = r > 10 ? 13 : r;
      pm = r == 13 ? 2 : r == 0 ? rnd(3) : 0;
      cm = rnd(3);
      am = r == 0 || r == 13 ? 0 : rnd(6);
      op_i <= ict_pkg::ict_op_t'(4'(r));
      pmove_i <= ict_pkg::ict_pmove_t'(2'(pm));
      cmode_i <= ict_pkg::ict_cmode_t'(2'(cm));
      amode_i <= ict_pkg::ict_amode_t'(3'(am));
      mem_opnd_i <= r == 5 || rnd(2) == 1;
      cond_true_i <= rnd(2) == 1;
      two_word_i <= r > 6 && r < 10;
      {xa_i, xb_i, pa_i, pd_i, fa_i} <=
        80'({$random(seed), $random(seed), $random(seed)});
      xws <= i < 12 ? 8'h0 : 8'(rnd(8));
      pws <= i % 6 == 0 ? 8'h7 : 8'(rnd(8));
      op_wait();
      chk(8'(n - 1), 8'(exp_cost()));
      chk(8'(ic), 8'(exp_cost() / 2));
      chk(cost_o, 8'(exp_cost()));
    end
    op_i <= ict_pkg::ICT_OP_IDLE;
    int_pending_i <= 1'h1;
    op_wait();
    chk(8'(n - 1 >= 16), 8'h1);
    // Issue held high while busy must be ignored
    int_pending_i <= 1'h0;
    issue_i <= 1'h1;
    repeat (30) @(posedge mclk_i);
    issue_i <= 1'h0;
    @(negedge mclk_i);
    chk(8'(busy_o), 8'h1);
    @(posedge mclk_i);
    int_pending_i <= 1'h1;
    wt(1'h0);
    @(posedge mclk_i);
    int_pending_i <= 1'h0;
    op_i <= ict_pkg::ICT_OP_HALT;
    issue_i <= 1'h1;
    @(posedge mclk_i);
    issue_i <= 1'h0;
    @(negedge mclk_i);
    chk(8'({osc_en_o, cen}), 8'h0);
    repeat (5) @(posedge mclk_i);
    osc_restart_i <= 1'h1;
    wt(1'h1);
    chk(8'(n >= RC && n <= RC + 3), 8'h1);
    repeat (4) @(posedge mclk_i);
    osc_restart_i <= 1'h0;
    r = 0;
    pm = 0;
    am = 0;
    op_i <= ict_pkg::ICT_OP_SIMPLE;
    pmove_i <= ict_pkg::ICT_PM_NONE;
    amode_i <= ict_pkg::ICT_AM_NONE;
    op_wait();
    chk(8'(n - 1), 8'(exp_cost()));
    tally_and_finish();
  end
endmodule
`default_nettype wire
